// ### rtl/tsf_map.vh
// Bit positions, reset values and constants of the channel 4/5 status flags
`ifndef TSF_MAP_VH
`define TSF_MAP_VH

// ==========================================================
// Status word layout
`define TSF_WORD_W        16
`define TSF_FLAG_COUNT    8
`define TSF_FLAG_LSB      5
`define TSF_FLAG_MSB      12
`define TSF_BIT_LO_A      5
`define TSF_BIT_LO_B      6
`define TSF_BIT_LO_C      7
`define TSF_BIT_LO_D      8
`define TSF_BIT_LO_WRAP   9
`define TSF_BIT_HI_A      10
`define TSF_BIT_HI_B      11
`define TSF_BIT_HI_C      12

// ==========================================================
// Flag vector index inside the block
`define TSF_IDX_LO_A      0
`define TSF_IDX_LO_B      1
`define TSF_IDX_LO_C      2
`define TSF_IDX_LO_D      3
`define TSF_IDX_LO_WRAP   4
`define TSF_IDX_HI_A      5
`define TSF_IDX_HI_B      6
`define TSF_IDX_HI_C      7

// ==========================================================
// Counter values and reset values
`define TSF_CNT_W         16
`define TSF_CNT_ONES      16'hffff
`define TSF_CNT_ZERO      16'h0000
`define TSF_WORD_RESET    16'h0000
`define TSF_FLAGS_RESET   8'h00
`define TSF_BIT_RESET     1'b0
`define TSF_BIT_SET       1'b1

`endif

// ### rtl/tsf_flag_cell.v
// One read-then-write-zero clearable status flag
`default_nettype none

module tsf_flag_cell (
  // Clock and reset
  input  wire clock_in,
  input  wire rst_n_in,
  // Hardware event
  input  wire set_in,
  // Software access
  input  wire read_in,
  input  wire write_in,
  input  wire wdata_bit_in,
  // Flag state
  output reg  flag_out,
  output reg  armed_out
);

`include "tsf_map.vh"

  // ==========================================================
  // Flag and clear arming
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out  <= `TSF_BIT_RESET; // R9
      armed_out <= `TSF_BIT_RESET;
    end else begin
      // Set beats a clear landing in the same cycle
      if (set_in) begin
        flag_out <= `TSF_BIT_SET; // R11
      end else if (write_in && armed_out && (wdata_bit_in == `TSF_BIT_RESET)) begin
        flag_out <= `TSF_BIT_RESET; // R1
      end
      // Any write consumes the arm; a one written is simply ignored
      if (write_in) begin
        armed_out <= `TSF_BIT_RESET; // R1 R10
      end else if (read_in) begin
        armed_out <= flag_out; // R1
      end
    end
  end

endmodule // tsf_flag_cell

`default_nettype wire

// ### rtl/tsf_status_flags.v
// Status flags of the lower and higher timer channels (overflow, capture and compare match)
`default_nettype none

// Function
// R1: A flag clears only when software reads it as one and then writes zero to its position.
// R2: The lower channel wrap flag at bit 9 sets when its counter goes from all ones to zero.
// R3: Higher channel flags at bits 10 to 12 set on an input capture into a capture-configured register.
// R4: Higher channel flags also set on counter equality with a compare-configured register.
// R5: Lower channel flags at bits 5 to 8 set on an input capture into a capture-configured register.
// R6: Lower channel flags also set on counter equality with a compare-configured register.
// R7: The lower channel fourth register flag also sets on equality as the synchronous register in PWM mode.
// R8: In PWM mode the first three register flags of either channel never set.
// R9: After reset every flag reads zero.
// R10: Software writes only zero to these positions and only to clear; a one never sets a flag.
// R11: A setting event in the same cycle as a clearing write leaves the flag set.
module tsf_status_flags (
  // Clock and reset
  input  wire        clock_in,
  input  wire        rst_n_in,
  // Lower channel counter and general registers
  input  wire [15:0] ch_lo_counter_in,
  input  wire [15:0] ch_lo_general_a_in,
  input  wire [15:0] ch_lo_general_b_in,
  input  wire [15:0] ch_lo_general_c_in,
  input  wire [15:0] ch_lo_general_d_in,
  // Higher channel counter and general registers
  input  wire [15:0] ch_hi_counter_in,
  input  wire [15:0] ch_hi_general_a_in,
  input  wire [15:0] ch_hi_general_b_in,
  input  wire [15:0] ch_hi_general_c_in,
  // Register function: one means input capture, zero means output compare
  input  wire [3:0]  ch_lo_capture_mode_in,
  input  wire [2:0]  ch_hi_capture_mode_in,
  // PWM mode per channel
  input  wire        ch_lo_pwm_mode_in,
  input  wire        ch_hi_pwm_mode_in,
  // Input capture strobes, one cycle each
  input  wire [3:0]  ch_lo_capture_strobe_in,
  input  wire [2:0]  ch_hi_capture_strobe_in,
  // Software access to the status word
  input  wire        status_read_in,
  input  wire        status_write_in,
  input  wire [15:0] status_wdata_in,
  output reg  [15:0] status_rdata_out,
  // Flags
  output wire        ch_lo_reg_a_event_flag_out,
  output wire        ch_lo_reg_b_event_flag_out,
  output wire        ch_lo_reg_c_event_flag_out,
  output wire        ch_lo_reg_d_event_flag_out,
  output wire        ch_lo_wrap_flag_out,
  output wire        ch_hi_reg_a_event_flag_out,
  output wire        ch_hi_reg_b_event_flag_out,
  output wire        ch_hi_reg_c_event_flag_out
);

`include "tsf_map.vh"

  // ==========================================================
  // Helpers
  // Equality only counts on the cycle the counter takes the new value;
  // a stopped counter would otherwise re-set the flag on every cycle
  // and software could never clear it.
  function tsf_hit;
    input [`TSF_CNT_W-1:0] cnt;
    input [`TSF_CNT_W-1:0] prev;
    input [`TSF_CNT_W-1:0] gen;
    begin
      tsf_hit = (cnt == gen) && (cnt != prev);
    end
  endfunction

  function tsf_wrap;
    input [`TSF_CNT_W-1:0] cnt;
    input [`TSF_CNT_W-1:0] prev;
    begin
      tsf_wrap = (prev == `TSF_CNT_ONES) && (cnt == `TSF_CNT_ZERO);
    end
  endfunction

  // PWM mode silences the first three registers of a channel; only the
  // fourth register keeps responding there.
  function tsf_gate;
    input pwm;
    input cap;
    input cmp;
    begin
      tsf_gate = ~pwm & (cap | cmp);
    end
  endfunction

  // ==========================================================
  // Previous counter values
  reg  [15:0] ch_lo_counter_prev_reg;
  reg  [15:0] ch_hi_counter_prev_reg;

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ch_lo_counter_prev_reg <= `TSF_CNT_ZERO;
      ch_hi_counter_prev_reg <= `TSF_CNT_ZERO;
    end else begin
      ch_lo_counter_prev_reg <= ch_lo_counter_in;
      ch_hi_counter_prev_reg <= ch_hi_counter_in;
    end
  end

  // ==========================================================
  // Set conditions
  wire [3:0] lo_match;
  wire [2:0] hi_match;
  wire [3:0] lo_capture;
  wire [2:0] hi_capture;
  wire [3:0] lo_compare;
  wire [2:0] hi_compare;
  wire [7:0] flag_set;
  wire       lo_d_sync;

  assign lo_match[0] = tsf_hit(ch_lo_counter_in, ch_lo_counter_prev_reg, ch_lo_general_a_in);
  assign lo_match[1] = tsf_hit(ch_lo_counter_in, ch_lo_counter_prev_reg, ch_lo_general_b_in);
  assign lo_match[2] = tsf_hit(ch_lo_counter_in, ch_lo_counter_prev_reg, ch_lo_general_c_in);
  assign lo_match[3] = tsf_hit(ch_lo_counter_in, ch_lo_counter_prev_reg, ch_lo_general_d_in);
  assign hi_match[0] = tsf_hit(ch_hi_counter_in, ch_hi_counter_prev_reg, ch_hi_general_a_in);
  assign hi_match[1] = tsf_hit(ch_hi_counter_in, ch_hi_counter_prev_reg, ch_hi_general_b_in);
  assign hi_match[2] = tsf_hit(ch_hi_counter_in, ch_hi_counter_prev_reg, ch_hi_general_c_in);

  // A strobe on a compare register, or a match on a capture register, is dropped
  assign lo_capture = ch_lo_capture_strobe_in & ch_lo_capture_mode_in; // R5
  assign hi_capture = ch_hi_capture_strobe_in & ch_hi_capture_mode_in; // R3
  assign lo_compare = lo_match & ~ch_lo_capture_mode_in; // R6
  assign hi_compare = hi_match & ~ch_hi_capture_mode_in; // R4

  // First three registers of each channel are silent in PWM mode
  assign flag_set[`TSF_IDX_LO_A] = tsf_gate(ch_lo_pwm_mode_in, lo_capture[0], lo_compare[0]); // R8 R5 R6
  assign flag_set[`TSF_IDX_LO_B] = tsf_gate(ch_lo_pwm_mode_in, lo_capture[1], lo_compare[1]); // R8 R5 R6
  assign flag_set[`TSF_IDX_LO_C] = tsf_gate(ch_lo_pwm_mode_in, lo_capture[2], lo_compare[2]); // R8 R5 R6
  // In PWM mode the fourth register is the synchronous register, so
  // equality sets it regardless of its capture selection.
  assign lo_d_sync = ch_lo_pwm_mode_in & lo_match[3]; // R7
  assign flag_set[`TSF_IDX_LO_D] = lo_capture[3] | lo_compare[3] | lo_d_sync; // R5 R6 R7
  // Wrap ignores PWM mode and the capture selection
  assign flag_set[`TSF_IDX_LO_WRAP] = tsf_wrap(ch_lo_counter_in, ch_lo_counter_prev_reg); // R2
  assign flag_set[`TSF_IDX_HI_A] = tsf_gate(ch_hi_pwm_mode_in, hi_capture[0], hi_compare[0]); // R8 R3 R4
  assign flag_set[`TSF_IDX_HI_B] = tsf_gate(ch_hi_pwm_mode_in, hi_capture[1], hi_compare[1]); // R8 R3 R4
  assign flag_set[`TSF_IDX_HI_C] = tsf_gate(ch_hi_pwm_mode_in, hi_capture[2], hi_compare[2]); // R8 R3 R4

  // ==========================================================
  // Flag cells
  wire [7:0] flags;

  // Every cell sees the whole read and write and takes its own data bit
  genvar gi;
  generate
    for (gi = 0; gi < `TSF_FLAG_COUNT; gi = gi + 1) begin : g_flag
      tsf_flag_cell u_cell (
        .clock_in     (clock_in),
        .rst_n_in     (rst_n_in),
        .set_in       (flag_set[gi]),
        .read_in      (status_read_in),
        .write_in     (status_write_in),
        .wdata_bit_in (status_wdata_in[gi + `TSF_FLAG_LSB]),
        .flag_out     (flags[gi]),
        .armed_out    ()
      );
    end
  endgenerate

  assign ch_lo_reg_a_event_flag_out = flags[`TSF_IDX_LO_A];
  assign ch_lo_reg_b_event_flag_out = flags[`TSF_IDX_LO_B];
  assign ch_lo_reg_c_event_flag_out = flags[`TSF_IDX_LO_C];
  assign ch_lo_reg_d_event_flag_out = flags[`TSF_IDX_LO_D];
  assign ch_lo_wrap_flag_out        = flags[`TSF_IDX_LO_WRAP];
  assign ch_hi_reg_a_event_flag_out = flags[`TSF_IDX_HI_A];
  assign ch_hi_reg_b_event_flag_out = flags[`TSF_IDX_HI_B];
  assign ch_hi_reg_c_event_flag_out = flags[`TSF_IDX_HI_C];

  // ==========================================================
  // Read data
  // Positions outside this block read zero; the word is registered, so
  // data follow the read strobe by one cycle.
  reg [15:0] status_word;

  always @* begin
    status_word = `TSF_WORD_RESET;
    status_word[`TSF_BIT_LO_A]    = flags[`TSF_IDX_LO_A];
    status_word[`TSF_BIT_LO_B]    = flags[`TSF_IDX_LO_B];
    status_word[`TSF_BIT_LO_C]    = flags[`TSF_IDX_LO_C];
    status_word[`TSF_BIT_LO_D]    = flags[`TSF_IDX_LO_D];
    status_word[`TSF_BIT_LO_WRAP] = flags[`TSF_IDX_LO_WRAP];
    status_word[`TSF_BIT_HI_A]    = flags[`TSF_IDX_HI_A];
    status_word[`TSF_BIT_HI_B]    = flags[`TSF_IDX_HI_B];
    status_word[`TSF_BIT_HI_C]    = flags[`TSF_IDX_HI_C];
  end

  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_rdata_out <= `TSF_WORD_RESET; // R9
    end else if (status_read_in) begin
      status_rdata_out <= status_word;
    end
  end

endmodule // tsf_status_flags

`default_nettype wire

// ### verification/tsf_status_checker.sv
// Port-level assertions for the channel 4/5 status flags
`default_nettype none
module tsf_status_checker (
  // ====
  // Watched ports
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] ch_lo_counter_in,
  input wire logic [15:0] ch_lo_general_d_in,
  input wire logic [3:0]  ch_lo_capture_mode_in,
  input wire logic [3:0]  ch_lo_capture_strobe_in,
  input wire logic        ch_lo_pwm_mode_in,
  input wire logic        ch_hi_pwm_mode_in,
  input wire logic        status_read_in,
  input wire logic        status_write_in,
  input wire logic [15:0] status_wdata_in,
  input wire logic [15:0] status_rdata_out,
  input wire logic        ch_lo_reg_a_event_flag_out,
  input wire logic        ch_lo_reg_d_event_flag_out,
  input wire logic        ch_lo_wrap_flag_out,
  input wire logic        ch_hi_reg_b_event_flag_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Counter history is cleared by reset, so the first edge after release is excluded
  a_wrap_sets: assert property ($past(rst_n_in) && $past(ch_lo_counter_in) == 16'hffff &&
    ch_lo_counter_in == 16'h0000 |=> ch_lo_wrap_flag_out) else $error("wrap flag not set");
  a_capture_sets: assert property (ch_lo_capture_strobe_in[0] && ch_lo_capture_mode_in[0] &&
    !ch_lo_pwm_mode_in |=> ch_lo_reg_a_event_flag_out) else $error("capture flag not set");
  a_pwm_blocks_lo: assert property (ch_lo_pwm_mode_in && !ch_lo_reg_a_event_flag_out |=>
    !ch_lo_reg_a_event_flag_out) else $error("flag set in pwm mode");
  a_pwm_blocks_hi: assert property (ch_hi_pwm_mode_in && !ch_hi_reg_b_event_flag_out |=>
    !ch_hi_reg_b_event_flag_out) else $error("flag set in pwm mode");
  a_flag_holds: assert property (ch_lo_wrap_flag_out && !status_write_in |=> ch_lo_wrap_flag_out)
    else $error("flag dropped without write");
  a_one_keeps: assert property (ch_lo_wrap_flag_out && status_write_in && status_wdata_in[9] |=>
    ch_lo_wrap_flag_out) else $error("flag dropped on write of one");
  a_read_data: assert property (status_read_in |=> status_rdata_out[9] == $past(ch_lo_wrap_flag_out) &&
    status_rdata_out[15:13] == 3'h0 && status_rdata_out[4:0] == 5'h00) else $error("bad read data");
  a_pwm_sync_d: assert property ($past(rst_n_in) && ch_lo_pwm_mode_in && ch_lo_counter_in == ch_lo_general_d_in &&
    ch_lo_counter_in != $past(ch_lo_counter_in) |=> ch_lo_reg_d_event_flag_out) else $error("sync flag not set");
endmodule // tsf_status_checker
bind tsf_status_flags tsf_status_checker tsf_status_checker_i (.clock_in, .rst_n_in, .ch_lo_counter_in,
  .ch_lo_general_d_in, .ch_lo_capture_mode_in, .ch_lo_capture_strobe_in, .ch_lo_pwm_mode_in, .ch_hi_pwm_mode_in,
  .status_read_in, .status_write_in, .status_wdata_in, .status_rdata_out, .ch_lo_reg_a_event_flag_out,
  .ch_lo_reg_d_event_flag_out, .ch_lo_wrap_flag_out, .ch_hi_reg_b_event_flag_out);
`default_nettype wire

// ### verification/tsf_status_flags_test.sv
// Self-checking bench of the channel 4/5 status flags
`default_nettype none
module tsf_status_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Row: compare target per channel (0 none), strobes, modes, pwm, expected flags
  typedef struct packed {
    logic [2:0] lk, hk;
    logic [3:0] ls;
    logic [2:0] hs;
    logic [3:0] lm;
    logic [2:0] hm;
    logic       lp, hp;
    logic [7:0] ex;
  } tsf_row_t;
  tsf_row_t rows [10] = '{
    '{3'h0,3'h0,4'hf,3'h0,4'hf,3'h0,1'b0,1'b0,8'h0f}, '{3'h0,3'h0,4'h0,3'h7,4'h0,3'h7,1'b0,1'b0,8'he0},
    '{3'h1,3'h1,4'hc,3'h6,4'h3,3'h1,1'b0,1'b0,8'h00}, '{3'h1,3'h1,4'h0,3'h0,4'h0,3'h0,1'b0,1'b0,8'h21},
    '{3'h4,3'h2,4'h0,3'h0,4'h0,3'h0,1'b0,1'b0,8'h48}, '{3'h3,3'h3,4'h0,3'h0,4'h0,3'h0,1'b0,1'b0,8'h84},
    '{3'h0,3'h0,4'hf,3'h0,4'hf,3'h0,1'b1,1'b0,8'h08}, '{3'h4,3'h0,4'h0,3'h0,4'hf,3'h0,1'b1,1'b0,8'h08},
    '{3'h1,3'h0,4'h0,3'h0,4'h0,3'h0,1'b1,1'b0,8'h00}, '{3'h2,3'h1,4'h0,3'h6,4'h0,3'h6,1'b0,1'b1,8'h02}};
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [15:0] lc = 16'h0, hc = 16'h0, base = 16'h0, wd = 16'h0;
  logic [3:0]  ls = 4'h0, lm = 4'h0;
  logic [2:0]  hs = 3'h0, hm = 3'h0;
  logic        lp = 1'b0, hp = 1'b0, rd = 1'b0, wr = 1'b0;
  wire  [15:0] rdat;
  wire  [7:0]  fl;
  tsf_row_t    r;
  int          mismatches = 0, comparisons = 0, cycles = 0;
  always #10 clock_in = ~clock_in;
  // General registers move with each row so no compare value stays fixed
  tsf_status_flags tsf_status_flags_i (.clock_in, .rst_n_in, .ch_lo_counter_in(lc), .ch_hi_counter_in(hc),
    .ch_lo_general_a_in(base + 16'h0010), .ch_lo_general_b_in(base + 16'h0020), .ch_lo_general_c_in(base + 16'h0030),
    .ch_lo_general_d_in(base + 16'h0040), .ch_hi_general_a_in(base + 16'h0010), .ch_hi_general_b_in(base + 16'h0020),
    .ch_hi_general_c_in(base + 16'h0030), .ch_lo_capture_mode_in(lm), .ch_hi_capture_mode_in(hm),
    .ch_lo_pwm_mode_in(lp), .ch_hi_pwm_mode_in(hp), .ch_lo_capture_strobe_in(ls), .ch_hi_capture_strobe_in(hs),
    .status_read_in(rd), .status_write_in(wr), .status_wdata_in(wd), .status_rdata_out(rdat),
    .ch_lo_reg_a_event_flag_out(fl[0]), .ch_lo_reg_b_event_flag_out(fl[1]), .ch_lo_reg_c_event_flag_out(fl[2]),
    .ch_lo_reg_d_event_flag_out(fl[3]), .ch_lo_wrap_flag_out(fl[4]), .ch_hi_reg_a_event_flag_out(fl[5]),
    .ch_hi_reg_b_event_flag_out(fl[6]), .ch_hi_reg_c_event_flag_out(fl[7]));
  // ====
  // Tasks
  task automatic step();
    @(posedge clock_in);
    #1;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic clear(input logic [7:0] ex);
    step();
    rd = 1'b1;
    step();
    {rd, wr, wd} = {1'b0, 1'b1, 16'h0000};
    check(rdat, {3'h0, ex, 5'h00});
    step();
    wr = 1'b0;
    check(16'(fl), 16'h0000);
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 1000) begin
      mismatches++;
      end_sim();
    end
  end
  // ====
  // Sequence
  initial begin
    repeat (4) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    check(16'(fl), 16'h0000);
    check(rdat, 16'h0000);
    for (int i = 0; i < 10; i++) begin
      r = rows[i];
      step();
      base = 16'((i + 1) * 256);
      lc = base + 16'({r.lk, 4'h0});
      hc = base + 16'({r.hk, 4'h0});
      {ls, hs, lm, hm, lp, hp} = {r.ls, r.hs, r.lm, r.hm, r.lp, r.hp};
      step();
      {ls, hs, lc, hc} = {4'h0, 3'h0, base, base};
      check(16'(fl), 16'(r.ex));
      clear(r.ex);
    end
    {lm, lp, hp, lc} = {4'hf, 1'b0, 1'b0, 16'hffff};
    step();
    lc = 16'h0000;
    step();
    check(16'(fl), 16'h0010);
    wr = 1'b1;
    step();
    wr = 1'b0;
    step();
    check(16'(fl), 16'h0010);
    rd = 1'b1;
    step();
    {rd, wr, wd} = {1'b0, 1'b1, 16'h0200};
    step();
    {wr, ls} = {1'b0, 4'h1};
    step();
    check(16'(fl), 16'h0011);
    {ls, rd} = {4'h0, 1'b1};
    step();
    {rd, wr, wd, ls} = {1'b0, 1'b1, 16'h0000, 4'h1};
    step();
    {wr, ls} = {1'b0, 4'h0};
    check(16'(fl), 16'h0001);
    // A counter parked on a compare value must not set the flag again once cleared
    {lm, lc} = {4'h0, 16'h0a10};
    step();
    rd = 1'b1;
    step();
    {rd, wr, wd} = {1'b0, 1'b1, 16'h0000};
    step();
    wr = 1'b0;
    step();
    check(16'(fl), 16'h0000);
    rst_n_in = 1'b0;
    #1;
    check(16'(fl), 16'h0000);
    check(rdat, 16'h0000);
    {lc, ls, lm} = {16'h0000, 4'h1, 4'h1};
    step();
    rst_n_in = 1'b1;
    step();
    ls = 4'h0;
    check(16'(fl), 16'h0001);
    check(rdat, 16'h0000);
    end_sim();
  end
endmodule // tsf_status_flags_test
`default_nettype wire
